// *** common/sio_pkg.sv ***
// Package for the safe I/O source and paired input monitor block.
// Assumes a 250 MHz system clock and an Avalon-MM register slave.
package sio_pkg;

    // ------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------
    localparam int SIO_NUM_OUT = 4;
    localparam int SIO_NUM_IN = 4;
    localparam int SIO_NUM_PAIR = 2;
    localparam int SIO_NUM_FUNC = 70;           // Function status vector width
    localparam int SIO_CLK_MHZ = 250;
    localparam int SIO_MISMATCH_MS = 100;
    localparam int SIO_MISMATCH_CYC = SIO_MISMATCH_MS * 1000 * SIO_CLK_MHZ;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [5:0] SIO_REG_SRC0 = 6'h00;
    localparam logic [5:0] SIO_REG_SRC1 = 6'h04;
    localparam logic [5:0] SIO_REG_SRC2 = 6'h08;
    localparam logic [5:0] SIO_REG_SRC3 = 6'h0c;
    localparam logic [5:0] SIO_REG_PSRC0 = 6'h10;
    localparam logic [5:0] SIO_REG_PSRC1 = 6'h14;
    localparam logic [5:0] SIO_REG_PEN = 6'h18;
    localparam logic [5:0] SIO_REG_STATE = 6'h1c;
    localparam logic [5:0] SIO_REG_IRQ_STAT = 6'h20;
    localparam logic [5:0] SIO_REG_IRQ_MASK = 6'h24;

    // ------------------------------------------------------------
    // State register field positions
    // ------------------------------------------------------------
    localparam int SIO_ST_IN_LSB = 0;           // [3:0] input states
    localparam int SIO_ST_OUT_LSB = 4;          // [7:4] output states
    localparam int SIO_ST_PIN_LSB = 8;          // [9:8] paired input states
    localparam int SIO_ST_PIN_VLD = 10;         // [11:10] paired inputs agree
    localparam int SIO_ST_POUT_LSB = 12;        // [13:12] paired output states
    localparam int SIO_ST_POUT_VLD = 14;        // [15:14] paired outputs agree
    localparam int SIO_ST_FAULT = 16;           // Latched I/O failure

    // Interrupt status bits: per pair mismatch start, fault
    localparam int SIO_IRQ_MIS0 = 0;
    localparam int SIO_IRQ_MIS1 = 1;
    localparam int SIO_IRQ_FAULT = 2;
    localparam int SIO_IRQ_W = 3;

    // ------------------------------------------------------------
    // Selector codes
    // ------------------------------------------------------------
    localparam logic [7:0] SIO_SEL_OFF = 8'h00;
    localparam logic [7:0] SIO_SEL_TORQUE_OFF_LO = 8'h01;
    localparam logic [7:0] SIO_SEL_BRAKE_FUNC_HI = 8'h40;
    localparam logic [7:0] SIO_SEL_READY = 8'h43;
    localparam logic [7:0] SIO_SEL_RESTART_A1 = 8'h45;
    localparam logic [7:0] SIO_SEL_RESTART_A2 = 8'h46;
    localparam logic [7:0] SIO_SEL_ALWAYS_ON = 8'hff;
    // Function vector slots for restart requests
    localparam int SIO_FN_RESTART_A1 = 64;
    localparam int SIO_FN_RESTART_A2 = 65;

    // Reset values of the selectors
    localparam logic [7:0] SIO_RST_SRC0 = 8'hff;
    localparam logic [7:0] SIO_RST_SRC1 = 8'hff;
    localparam logic [7:0] SIO_RST_SRC2 = 8'h00;
    localparam logic [7:0] SIO_RST_SRC3 = 8'hff;
    localparam logic [7:0] SIO_RST_PSRC = 8'h00;
    localparam logic [1:0] SIO_RST_PEN = 2'h0;
    localparam logic [SIO_IRQ_W-1:0] SIO_RST_MASK = 3'h0;

    // Avalon-MM request bundle
    typedef struct packed {
        logic [5:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } sio_avm_req_t;

    // Bus slave states
    typedef enum logic [1:0] {
        SIO_BUS_IDLE = 2'b01,
        SIO_BUS_ACK = 2'b10
    } sio_bus_state_t;

endpackage

// *** core/sio_safe_io.sv ***
// Safe output source routing, paired input monitor and I/O state readback.
// Assumes function status arrives on clk_i; field inputs are asynchronous.
`timescale 1ns/1ns
`default_nettype none

module sio_safe_io
    import sio_pkg::*;
#(
    parameter int MISMATCH_CYC = SIO_MISMATCH_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Avalon-MM slave
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [1:0] avs_response_o,
    // Safety function status, slot n-1 for code n in 01h-40h, slots 64 and 65 for codes 45h and 46h
    input wire logic [SIO_NUM_FUNC-1:0] func_status_i,
    // Field pins
    input wire logic [SIO_NUM_IN-1:0] safe_input_i,
    output logic [SIO_NUM_OUT-1:0] safe_output_o,
    // Fault and interrupt
    output logic io_failure_o,
    output logic safe_state_req_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // Selector decode
    // ------------------------------------------------------------
    // Map a selector to its function status bit
    function automatic logic sel_status(input logic [7:0] sel,
                                        input logic [SIO_NUM_FUNC-1:0] fs);
        logic r;
        r = 1'b0;
        if (sel == SIO_SEL_ALWAYS_ON || sel == SIO_SEL_READY) begin
            r = 1'b1;
        end else if (sel >= SIO_SEL_TORQUE_OFF_LO && sel <= SIO_SEL_BRAKE_FUNC_HI) begin
            r = fs[7'(sel - 8'h01)];
        end else if (sel == SIO_SEL_RESTART_A1) begin
            r = fs[SIO_FN_RESTART_A1];
        end else if (sel == SIO_SEL_RESTART_A2) begin
            r = fs[SIO_FN_RESTART_A2];
        end
        // Zero and unassigned codes stay off
        return r;
    endfunction

    // ------------------------------------------------------------
    // Registers and input synchronisers
    // ------------------------------------------------------------
    logic [7:0] src_sel [SIO_NUM_OUT];
    logic [7:0] pair_sel [SIO_NUM_PAIR];
    logic [SIO_NUM_PAIR-1:0] pair_en;
    logic [SIO_IRQ_W-1:0] irq_stat;
    logic [SIO_IRQ_W-1:0] irq_mask;
    logic [SIO_NUM_IN-1:0] in_meta;
    logic [SIO_NUM_IN-1:0] in_sync;
    logic [SIO_NUM_PAIR-1:0] mis_prev;
    logic [31:0] mis_cnt [SIO_NUM_PAIR];
    logic fault;
    sio_bus_state_t bus_state;
    sio_avm_req_t req;

    assign req = '{address: avs_address_i, read: avs_read_i, write: avs_write_i,
                   writedata: avs_writedata_i, byteenable: avs_byteenable_i};

    // Two-flop synchroniser for field inputs
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            in_meta <= '0;
            in_sync <= '0;
        end else begin
            in_meta <= safe_input_i;
            in_sync <= in_meta;
        end
    end

    // ------------------------------------------------------------
    // Output routing
    // ------------------------------------------------------------
    logic [SIO_NUM_OUT-1:0] next_out;
    logic [SIO_NUM_PAIR-1:0] pair_drive;
    logic [SIO_NUM_PAIR-1:0] pair_in_state;
    logic [SIO_NUM_PAIR-1:0] pair_in_vld;
    logic [SIO_NUM_PAIR-1:0] pair_out_state;
    logic [SIO_NUM_PAIR-1:0] pair_out_vld;
    logic [SIO_NUM_PAIR-1:0] mismatch;
    logic [SIO_NUM_PAIR-1:0] mis_expired;

    // Pair p joins inputs 2p,2p+1 and outputs 2p,2p+1
    genvar gp;
    generate
        for (gp = 0; gp < SIO_NUM_PAIR; gp++) begin : g_pair
            assign pair_drive[gp] = sel_status(pair_sel[gp], func_status_i);
            // Both outputs follow the paired source
            assign next_out[2*gp] = pair_en[gp] ? pair_drive[gp]
                                                : sel_status(src_sel[2*gp], func_status_i);
            assign next_out[2*gp+1] = pair_en[gp] ? pair_drive[gp]
                                                  : sel_status(src_sel[2*gp+1], func_status_i);
            // Paired input from two physical inputs
            assign pair_in_state[gp] = in_sync[2*gp] & in_sync[2*gp+1];
            assign pair_in_vld[gp] = ~(in_sync[2*gp] ^ in_sync[2*gp+1]);
            assign mismatch[gp] = pair_en[gp] & ~pair_in_vld[gp];
            assign mis_expired[gp] = mis_cnt[gp] >= 32'(MISMATCH_CYC);
            // Paired output readback
            assign pair_out_state[gp] = safe_output_o[2*gp] & safe_output_o[2*gp+1];
            assign pair_out_vld[gp] = ~(safe_output_o[2*gp] ^ safe_output_o[2*gp+1]);

            // Disagreement timer, runs only while paired and unequal
            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    mis_cnt[gp] <= '0;
                end else if (!mismatch[gp]) begin
                    mis_cnt[gp] <= '0;
                end else if (!mis_expired[gp]) begin
                    mis_cnt[gp] <= mis_cnt[gp] + 32'h1;
                end
            end
        end
    endgenerate

    // Safe state forces every output off while the fault stands
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            safe_output_o <= '0;
        end else begin
            safe_output_o <= fault ? '0 : next_out;
        end
    end

    // Latched fault, cleared only by reset
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            fault <= 1'b0;
            mis_prev <= '0;
        end else begin
            fault <= fault | (|mis_expired);
            mis_prev <= mismatch;
        end
    end

    assign io_failure_o = fault;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            safe_state_req_o <= 1'b0;
        end else begin
            safe_state_req_o <= fault | (|mis_expired);
        end
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire bus_req = (req.read | req.write) & (bus_state == SIO_BUS_IDLE);
    wire wr_en = bus_req & req.write;
    wire wr_lo = wr_en & req.byteenable[0];
    wire hit_src0 = req.address == SIO_REG_SRC0;
    wire hit_src1 = req.address == SIO_REG_SRC1;
    wire hit_src2 = req.address == SIO_REG_SRC2;
    wire hit_src3 = req.address == SIO_REG_SRC3;
    wire hit_psrc0 = req.address == SIO_REG_PSRC0;
    wire hit_psrc1 = req.address == SIO_REG_PSRC1;
    wire hit_pen = req.address == SIO_REG_PEN;
    wire hit_state = req.address == SIO_REG_STATE;
    wire hit_istat = req.address == SIO_REG_IRQ_STAT;
    wire hit_imask = req.address == SIO_REG_IRQ_MASK;
    wire hit_any = hit_src0 | hit_src1 | hit_src2 | hit_src3 | hit_psrc0 | hit_psrc1
                   | hit_pen | hit_state | hit_istat | hit_imask;

    // State word: inputs, outputs, paired readback, fault
    wire [31:0] state_word = {15'h0, fault, pair_out_vld, pair_out_state, pair_in_vld,
                              pair_in_state, safe_output_o, in_sync};

    wire [31:0] rd_mux = hit_src0 ? {24'h0, src_sel[0]} :
                         hit_src1 ? {24'h0, src_sel[1]} :
                         hit_src2 ? {24'h0, src_sel[2]} :
                         hit_src3 ? {24'h0, src_sel[3]} :
                         hit_psrc0 ? {24'h0, pair_sel[0]} :
                         hit_psrc1 ? {24'h0, pair_sel[1]} :
                         hit_pen ? {30'h0, pair_en} :
                         hit_state ? state_word :
                         hit_istat ? {29'h0, irq_stat} :
                         hit_imask ? {29'h0, irq_mask} : 32'h0;

    // Answer one cycle after the request, waitrequest low in that cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bus_state <= SIO_BUS_IDLE;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= '0;
            avs_response_o <= 2'h0;
        end else begin
            unique case (bus_state)
                SIO_BUS_IDLE: begin
                    if (bus_req) begin
                        bus_state <= SIO_BUS_ACK;
                        avs_waitrequest_o <= 1'b0;
                        avs_readdata_o <= req.read ? rd_mux : 32'h0;
                        avs_response_o <= hit_any ? 2'h0 : 2'h2; // Unmapped: slave error
                    end
                end
                SIO_BUS_ACK: begin
                    bus_state <= SIO_BUS_IDLE;
                    avs_waitrequest_o <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Selectors reload defaults at every reset
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            src_sel[0] <= SIO_RST_SRC0;
            src_sel[1] <= SIO_RST_SRC1;
            src_sel[2] <= SIO_RST_SRC2;
            src_sel[3] <= SIO_RST_SRC3;
            pair_sel[0] <= SIO_RST_PSRC;
            pair_sel[1] <= SIO_RST_PSRC;
            pair_en <= SIO_RST_PEN;
            irq_mask <= SIO_RST_MASK;
        end else if (wr_lo) begin
            if (hit_src0) src_sel[0] <= req.writedata[7:0];
            if (hit_src1) src_sel[1] <= req.writedata[7:0];
            if (hit_src2) src_sel[2] <= req.writedata[7:0];
            if (hit_src3) src_sel[3] <= req.writedata[7:0];
            if (hit_psrc0) pair_sel[0] <= req.writedata[7:0];
            if (hit_psrc1) pair_sel[1] <= req.writedata[7:0];
            if (hit_pen) pair_en <= req.writedata[1:0];
            if (hit_imask) irq_mask <= req.writedata[SIO_IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    wire [SIO_IRQ_W-1:0] irq_event = {(|mis_expired) & ~fault, mismatch & ~mis_prev};
    wire [SIO_IRQ_W-1:0] irq_clr = (wr_lo & hit_istat) ? req.writedata[SIO_IRQ_W-1:0]
                                                       : {SIO_IRQ_W{1'b0}};

    // Set wins over write-one clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            irq_stat <= '0;
            irq_o <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_event;
            irq_o <= |(((irq_stat & ~irq_clr) | irq_event) & irq_mask);
        end
    end

endmodule

`default_nettype wire

// *** sim/sio_field_model.sv ***
// Field wiring model: two sensor channels per pair.
// Assumes the bench sets levels just after a clock edge.
`timescale 1ns/1ns
`default_nettype none
module sio_field_model (
    // Commanded sensor levels and channel skew
    input wire logic [1:0] level_i,
    input wire logic [1:0] skew_i,
    // Pins into the block
    output logic [3:0] safe_input_o
);
    // ----------
    // Pair wiring
    // ----------
    // Second channel of a pair flips while skewed
    assign safe_input_o = {level_i[1] ^ skew_i[1], level_i[1],
        level_i[0] ^ skew_i[0], level_i[0]};
endmodule
`default_nettype wire

// *** sim/sio_safe_io_properties.sv ***
// Checker for bus answer, unmapped reads, fault and mask timing.
// Assumes one clock domain; bound into the block below.
`timescale 1ns/1ns
`default_nettype none
module sio_safe_io_properties
    import sio_pkg::*;
#(
    parameter int MISMATCH_CYC = SIO_MISMATCH_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Register bus
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [1:0] avs_response_o,
    // Field side and fault
    input wire logic [SIO_NUM_FUNC-1:0] func_status_i,
    input wire logic [SIO_NUM_IN-1:0] safe_input_i,
    input wire logic [SIO_NUM_OUT-1:0] safe_output_o,
    input wire logic io_failure_o,
    input wire logic safe_state_req_o,
    input wire logic irq_o
);
    // ----------
    // Helpers
    // ----------
    int mis_cnt [2];
    logic unmapped;
    assign unmapped = avs_address_i > SIO_REG_IRQ_MASK || avs_address_i[1:0] != 2'h0;
    // Raw disagreement length per pair, saturating
    always_ff @(posedge clk_i) begin
        for (int p = 0; p < 2; p++) begin
            if (reset_i || safe_input_i[2*p] == safe_input_i[2*p+1]) begin
                mis_cnt[p] <= 0;
            end else if (mis_cnt[p] < MISMATCH_CYC) begin
                mis_cnt[p] <= mis_cnt[p] + 1;
            end
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // ----------
    // Assertions
    // ----------
    reset_idle_a: assert property ($fell(reset_i) |->
        safe_output_o == '0 && !irq_o && avs_waitrequest_o) else $error("not idle after reset");
    bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |-> ##[1:3] !avs_waitrequest_o) else $error("bus request not answered");
    wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    out_readback_a: assert property (avs_read_i && !avs_waitrequest_o
        && avs_address_i == SIO_REG_STATE |-> avs_readdata_o[7:4] == $past(safe_output_o))
        else $error("output state readback wrong");
    unmapped_a: assert property (avs_read_i && !avs_waitrequest_o && unmapped
        |-> avs_readdata_o == '0 && avs_response_o == 2'h2) else $error("unmapped read");
    fault_off_a: assert property (io_failure_o |=> safe_output_o == '0)
        else $error("outputs driven during fault");
    fault_hold_a: assert property (io_failure_o |=> io_failure_o && safe_state_req_o)
        else $error("fault not held");
    fault_late_a: assert property ($rose(io_failure_o) |->
        mis_cnt[0] >= MISMATCH_CYC || mis_cnt[1] >= MISMATCH_CYC) else $error("fault too early");
    mask_off_a: assert property (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
        && avs_address_i == SIO_REG_IRQ_MASK && avs_writedata_i[2:0] == 3'h0 |=> !irq_o)
        else $error("irq high with mask cleared");
    cover property ($rose(io_failure_o));
    cover property ($rose(irq_o));
    cover property (avs_response_o == 2'h2 && !avs_waitrequest_o);
endmodule
bind sio_safe_io sio_safe_io_properties #(.MISMATCH_CYC(MISMATCH_CYC)) u_props (
    .clk_i(clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
    .func_status_i(func_status_i), .safe_input_i(safe_input_i), .safe_output_o(safe_output_o),
    .io_failure_o(io_failure_o), .safe_state_req_o(safe_state_req_o), .irq_o(irq_o));
`default_nettype wire

// *** sim/tb.sv ***
// Bench: selector codes, pairing, readback, mismatch fault, interrupts.
// Assumes the package, checker and field model compile first.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import sio_pkg::*;
    localparam int MC = 20;
    typedef struct packed {logic [7:0] code; logic [1:0] exp;} sio_row_t;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [5:0] avs_address_i = '0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = '0;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [1:0] avs_response_o;
    logic [SIO_NUM_FUNC-1:0] func_status_i = '0;
    wire logic [3:0] safe_input_i;
    logic [3:0] safe_output_o;
    logic io_failure_o;
    logic safe_state_req_o;
    logic irq_o;
    logic [1:0] lvl = 2'h0;
    logic [1:0] skew = 2'h0;
    logic [31:0] rd;
    logic [1:0] rsp;
    int n_mismatch = 0;
    int n_tests = 0;
    int i;
    // Code, then output with only its function on and with all others on
    sio_row_t rows [27] = '{{8'h00, 2'h0}, {8'h01, 2'h2}, {8'h02, 2'h2}, {8'h03, 2'h2},
        {8'h08, 2'h2}, {8'h0d, 2'h2}, {8'h0e, 2'h2}, {8'h0f, 2'h2}, {8'h14, 2'h2},
        {8'h17, 2'h2}, {8'h1d, 2'h2}, {8'h20, 2'h2}, {8'h23, 2'h2}, {8'h28, 2'h2},
        {8'h29, 2'h2}, {8'h2f, 2'h2}, {8'h35, 2'h2}, {8'h3a, 2'h2}, {8'h3b, 2'h2},
        {8'h40, 2'h2}, {8'h41, 2'h0}, {8'h43, 2'h3}, {8'h44, 2'h0}, {8'h45, 2'h2},
        {8'h46, 2'h2}, {8'h47, 2'h0}, {8'hff, 2'h3}};
    sio_safe_io #(.MISMATCH_CYC(MC)) uut (.clk_i(clk_i), .reset_i(reset_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .avs_response_o(avs_response_o), .func_status_i(func_status_i),
        .safe_input_i(safe_input_i), .safe_output_o(safe_output_o),
        .io_failure_o(io_failure_o), .safe_state_req_o(safe_state_req_o), .irq_o(irq_o));
    sio_field_model u_field (.level_i(lvl), .skew_i(skew), .safe_input_o(safe_input_i));
    // ----------
    // Helpers
    // ----------
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    function automatic logic [SIO_NUM_FUNC-1:0] onehot(input logic [7:0] c);
        onehot = '0;
        if (c >= 8'h01 && c <= 8'h40) onehot[c - 8'h01] = 1'b1;
        if (c == 8'h45) onehot[SIO_FN_RESTART_A1] = 1'b1;
        if (c == 8'h46) onehot[SIO_FN_RESTART_A2] = 1'b1;
    endfunction
    task automatic end_sim();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One bus cycle; held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int t;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        for (t = 0; t < 20; t++) begin
            @(posedge clk_i);
            if (avs_waitrequest_o === 1'b0) break;
        end
        rd = avs_readdata_o;
        rsp = avs_response_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (t == 20) begin
            n_mismatch++;
            $display("ERROR %0t bus timeout", $time);
            end_sim();
        end
    endtask
    task automatic do_reset();
        reset_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
    endtask
    task automatic settle();
        repeat (2) @(posedge clk_i);
    endtask
    // ----------
    // Main sequence
    // ----------
    initial begin
        do_reset();
        settle();
        ck(safe_output_o, 4'hb);
        for (i = 0; i < 4; i++) begin
            bus(1'b0, 6'(4 * i), 32'h0);
            ck(rd, i == 2 ? 32'h0 : 32'hff);
        end
        foreach (rows[r]) begin
            bus(1'b1, SIO_REG_SRC2, {24'h0, rows[r].code});
            func_status_i <= onehot(rows[r].code);
            settle();
            ck(safe_output_o[2], rows[r].exp[1]);
            func_status_i <= ~onehot(rows[r].code);
            settle();
            ck(safe_output_o[2], rows[r].exp[0]);
        end
        // Write without the low byte lane is dropped; unmapped read
        avs_byteenable_i <= 4'he;
        bus(1'b1, SIO_REG_SRC2, 32'h0);
        avs_byteenable_i <= 4'hf;
        bus(1'b0, SIO_REG_SRC2, 32'h0);
        ck(rd, 32'hff);
        bus(1'b0, 6'h28, 32'h0);
        ck({rsp, rd[29:0]}, 32'h8000_0000);
        // Paired outputs follow the paired selector only
        func_status_i <= '0;
        bus(1'b1, SIO_REG_PSRC0, 32'h1);
        bus(1'b1, SIO_REG_PEN, 32'h1);
        settle();
        ck(safe_output_o[1:0], 2'h0);
        func_status_i <= onehot(8'h01);
        settle();
        ck(safe_output_o[1:0], 2'h3);
        bus(1'b0, SIO_REG_STATE, 32'h0);
        ck({rd[14], rd[12], rd[7:4]}, 6'h3f);
        for (i = 1; i < 3; i++) begin
            lvl <= 2'(i);
            repeat (4) @(posedge clk_i);
            bus(1'b0, SIO_REG_STATE, 32'h0);
            ck({rd[10], rd[8], rd[3:0]}, i == 1 ? 6'h33 : 6'h2c);
        end
        do_reset();
        bus(1'b0, SIO_REG_PSRC0, 32'h0);
        ck(rd, 32'h0);
        bus(1'b0, SIO_REG_SRC2, 32'h0);
        ck(rd, 32'h0);
        // Short disagreement passes, long one faults
        bus(1'b1, SIO_REG_PEN, 32'h1);
        lvl <= 2'h1;
        skew <= 2'h1;
        repeat (MC / 2) @(posedge clk_i);
        skew <= 2'h0;
        repeat (MC) @(posedge clk_i);
        ck({io_failure_o, irq_o}, 2'h0);
        bus(1'b1, SIO_REG_IRQ_MASK, 32'h7);
        settle();
        ck(irq_o, 1'b1);
        skew <= 2'h1;
        for (i = 0; i < 200 && io_failure_o !== 1'b1; i++) @(posedge clk_i);
        ck(i >= MC && i <= MC + 6, 1'b1);
        settle();
        ck({safe_state_req_o, safe_output_o}, 5'h10);
        bus(1'b1, SIO_REG_IRQ_MASK, 32'h0);
        settle();
        ck(irq_o, 1'b0);
        bus(1'b1, SIO_REG_IRQ_MASK, 32'h7);
        bus(1'b1, SIO_REG_IRQ_STAT, 32'h7);
        settle();
        ck(irq_o, 1'b0);
        end_sim();
    end
    // Hang guard
    initial begin
        repeat (100000) @(posedge clk_i);
        n_mismatch++;
        $display("ERROR %0t run timeout", $time);
        end_sim();
    end
endmodule
`default_nettype wire
